// *** core/spfm_pkg.sv ***
// Constants and types shared by the four-mode serial port
package spfm_pkg;

  // ---------------------------------------------------------------
  // Clock and mode 0 shift timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20000000;
  localparam logic [3:0]  M0_PER_SLOW  = 4'hC;
  localparam logic [3:0]  M0_PER_FAST  = 4'h4;
  localparam logic [3:0]  M0_Q_SLOW    = 4'h3;
  localparam logic [3:0]  M0_Q_FAST    = 4'h1;
  localparam logic [2:0]  M0_LAST_BIT  = 3'h7;

  // ---------------------------------------------------------------
  // Oversampling and frame layout
  // ---------------------------------------------------------------
  localparam logic [3:0]  DIV_LAST     = 4'hF;
  localparam logic [3:0]  SAMPLE_A     = 4'h7;
  localparam logic [3:0]  SAMPLE_B     = 4'h8;
  localparam logic [3:0]  SAMPLE_C     = 4'h9;
  localparam logic [3:0]  TX_ROLL_M1   = 4'hA;
  localparam logic [3:0]  TX_ROLL_M23  = 4'hB;
  localparam logic [3:0]  RX_LAST_M1   = 4'h9;
  localparam logic [3:0]  RX_LAST_M23  = 4'hA;

  // ---------------------------------------------------------------
  // Sixteen-times tick pre-divider limits
  // ---------------------------------------------------------------
  localparam logic [1:0]  PRE_M2_FAST  = 2'h1;
  localparam logic [1:0]  PRE_M2_SLOW  = 2'h3;
  localparam logic [1:0]  PRE_TMR_FAST = 2'h0;
  localparam logic [1:0]  PRE_TMR_SLOW = 2'h1;

  // ---------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SPFM_MODE0, SPFM_MODE1, SPFM_MODE2, SPFM_MODE3} spfm_mode_t;
  typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} spfm_m0_state_t;
  typedef enum logic       {ATX_IDLE, ATX_RUN} spfm_atx_state_t;
  typedef enum logic       {ARX_HUNT, ARX_BITS} spfm_arx_state_t;

endpackage : spfm_pkg

// *** core/spfm_serial_port.sv ***
// Four-mode serial port: shift register mode and three asynchronous modes
`timescale 1ns/100ps
// What this block does
// [RULE_01] Mode 0: data both ways on data pin, shift clock out, 8 bits LSB first
// [RULE_02] Mode 0 shift rate is clock/12 with select 0, clock/4 with select 1
// [RULE_03] Fast mode 0 send: data one period before clock falls, low two periods
// [RULE_04] Slow mode 0 send: data three periods before clock falls, low six periods
// [RULE_05] Mode 0 sets transmit-done right after the last bit ends
// [RULE_06] Mode 0 receives when enabled and receive-done clear, latching on rising edges
// [RULE_07] Far end changes mode 0 data on the falling shift clock edge
// [RULE_08] Mode 0 sets receive-done after last rising edge, then stops until cleared
// [RULE_09] Mode 1 frame: start 0, 8 data bits LSB first, stop 1
// [RULE_10] Mode 1 bit rate is timer overflow /16 or /32
// [RULE_11] Async send starts on buffer write, bits on rollovers, mode 1 done at 10th
// [RULE_12] Modes 2 and 3 set transmit-done at the 11th rollover
// [RULE_13] Falling edge on data line resets the receive divide-by-16 counter
// [RULE_14] Each received bit is a two-of-three vote at states 7, 8, 9
// [RULE_15] A start bit that is not 0 aborts reception back to hunting
// [RULE_16] Load buffer and ninth bit only if done clear and select 0 or stop 1
// [RULE_17] After mid stop bit the receiver hunts for a falling edge again
// [RULE_18] Mode 2 frame: start, 8 data, ninth from control, stop; ninth received kept
// [RULE_19] Mode 2 bit rate is clock/32 or clock/64 by the doubler
// [RULE_20] Mode 3 is mode 2 with timer overflow baud
// [RULE_21] Two mode select bits choose one of the four modes
// [RULE_22] Far end begins each async transfer with a start bit
// [RULE_23] Buffer write loads transmit register; read shows receive buffer
// [RULE_24] Doubler set picks overflow/16 in modes 1 and 3, clock/32 in mode 2
// [RULE_25] Done flags stay set until software clears them
module spfm_serial_port (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       link_clk_i,
  input  wire logic       link_resetn_i,
  input  wire logic       timer_ovf_i,
  input  wire logic       mode_select_low_i,
  input  wire logic       mode_select_high_i,
  input  wire logic       speed_or_filter_select_i,
  input  wire logic       baud_doubler_i,
  input  wire logic       rx_enable_i,
  input  wire logic       tx_ninth_bit_i,
  input  wire logic [7:0] serial_buffer_wdata_i,
  input  wire logic       serial_buffer_we_i,
  input  wire logic       tx_done_clr_i,
  input  wire logic       rx_done_clr_i,
  input  wire logic       rxd_i,
  output logic      [7:0] serial_buffer_o,
  output logic            rx_ninth_bit_o,
  output logic            tx_done_flag_o,
  output logic            rx_done_flag_o,
  output logic            txd_o,
  output logic            rxd_o,
  output logic            rxd_oe_n_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  spfm_pkg::spfm_mode_t      mode;
  spfm_pkg::spfm_m0_state_t  m0_state;
  spfm_pkg::spfm_atx_state_t atx_state;
  spfm_pkg::spfm_arx_state_t arx_state;
  logic                      ovf_tgl;
  logic                      ovf_meta;
  logic                      ovf_s1;
  logic                      ovf_s2;
  logic                      ovf_pulse;
  logic                      rxd_meta;
  logic                      rxd_s;
  logic [1:0]                pre_cnt;
  logic [1:0]                pre_lim;
  logic                      pre_src;
  logic                      tick;
  logic [3:0]                m0_per;
  logic [3:0]                m0_q;
  logic [3:0]                m0_cnt;
  logic [2:0]                m0_bit;
  logic [7:0]                m0_sh;
  logic                      m0_fall;
  logic                      m0_rise;
  logic                      m0_end;
  logic                      m0_tx_set;
  logic                      m0_rx_set;
  logic [3:0]                tdiv;
  logic                      roll;
  logic [10:0]               tx_sh;
  logic [3:0]                tx_roll;
  logic [3:0]                tx_roll_lim;
  logic                      atx_set;
  logic [3:0]                rdiv;
  logic [3:0]                rcnt;
  logic [3:0]                rx_last_idx;
  logic                      rx_last;
  logic                      vote_a;
  logic                      vote_b;
  logic                      vote;
  logic                      rx_decide;
  logic [8:0]                rx_sh;
  logic                      arx_final;
  logic                      arx_load;
  logic [7:0]                arx_data;
  logic                      arx_ninth;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  assign mode = spfm_pkg::spfm_mode_t'({mode_select_high_i, mode_select_low_i}); // [RULE_21]

  // ---------------------------------------------------------------
  // Timer overflow crossing
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_i)
  begin
    if (!link_resetn_i)
      ovf_tgl <= 1'b0;
    else if (timer_ovf_i)
      ovf_tgl <= ~ovf_tgl;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ovf_meta <= 1'b0;
      ovf_s1   <= 1'b0;
      ovf_s2   <= 1'b0;
    end
    else
    begin
      ovf_meta <= ovf_tgl;
      ovf_s1   <= ovf_meta;
      ovf_s2   <= ovf_s1;
    end
  end

  assign ovf_pulse = ovf_s1 ^ ovf_s2;

  // ---------------------------------------------------------------
  // Data pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rxd_meta <= 1'b1;
      rxd_s    <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd_i;
      rxd_s    <= rxd_meta;
    end
  end

  // ---------------------------------------------------------------
  // Sixteen-times baud tick
  // ---------------------------------------------------------------
  always_comb
  begin
    pre_src = ovf_pulse; // [RULE_10] [RULE_20]
    if (mode == spfm_pkg::SPFM_MODE2)
    begin
      pre_src = 1'b1; // [RULE_19]
      pre_lim = baud_doubler_i ? spfm_pkg::PRE_M2_FAST : spfm_pkg::PRE_M2_SLOW; // [RULE_24]
    end
    else
      pre_lim = baud_doubler_i ? spfm_pkg::PRE_TMR_FAST : spfm_pkg::PRE_TMR_SLOW; // [RULE_24]
  end

  assign tick = pre_src && (pre_cnt >= pre_lim);

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      pre_cnt <= 2'h0;
    else if (tick)
      pre_cnt <= 2'h0;
    else if (pre_src)
      pre_cnt <= pre_cnt + 2'h1;
  end

  // ---------------------------------------------------------------
  // Mode 0 shift engine
  // ---------------------------------------------------------------
  assign m0_per  = speed_or_filter_select_i ? spfm_pkg::M0_PER_FAST : spfm_pkg::M0_PER_SLOW; // [RULE_02]
  assign m0_q    = speed_or_filter_select_i ? spfm_pkg::M0_Q_FAST : spfm_pkg::M0_Q_SLOW;
  assign m0_fall = (m0_cnt == m0_q - 4'h1); // [RULE_03] [RULE_04]
  assign m0_rise = (m0_cnt == 4'(3 * m0_q) - 4'h1); // [RULE_03] [RULE_04]
  assign m0_end  = (m0_cnt == m0_per - 4'h1) && (m0_bit == spfm_pkg::M0_LAST_BIT);
  assign m0_tx_set = (m0_state == spfm_pkg::M0_TX) && m0_end; // [RULE_05]
  assign m0_rx_set = (m0_state == spfm_pkg::M0_RX) && m0_end; // [RULE_08]

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      m0_state <= spfm_pkg::M0_IDLE;
      m0_cnt   <= 4'h0;
      m0_bit   <= 3'h0;
      m0_sh    <= 8'h00;
    end
    else if (mode != spfm_pkg::SPFM_MODE0)
      m0_state <= spfm_pkg::M0_IDLE;
    else if (serial_buffer_we_i)
    begin
      m0_state <= spfm_pkg::M0_TX; // [RULE_23]
      m0_cnt   <= 4'h0;
      m0_bit   <= 3'h0;
      m0_sh    <= serial_buffer_wdata_i;
    end
    else
    begin
      unique case (m0_state)
        spfm_pkg::M0_IDLE:
        begin
          if (rx_enable_i && !rx_done_flag_o) // [RULE_06] [RULE_08]
          begin
            m0_state <= spfm_pkg::M0_RX;
            m0_cnt   <= 4'h0;
            m0_bit   <= 3'h0;
          end
        end
        spfm_pkg::M0_TX, spfm_pkg::M0_RX:
        begin
          if (m0_cnt == m0_per - 4'h1)
          begin
            m0_cnt <= 4'h0;
            m0_bit <= m0_bit + 3'h1;
            if (m0_state == spfm_pkg::M0_TX)
              m0_sh <= {1'b1, m0_sh[7:1]}; // [RULE_01]
            else
              m0_sh <= {rxd_s, m0_sh[7:1]}; // [RULE_06] [RULE_07]
            if (m0_bit == spfm_pkg::M0_LAST_BIT)
              m0_state <= spfm_pkg::M0_IDLE;
          end
          else
            m0_cnt <= m0_cnt + 4'h1;
        end
        default:
          m0_state <= spfm_pkg::M0_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Asynchronous transmitter
  // ---------------------------------------------------------------
  assign roll        = tick && (tdiv == spfm_pkg::DIV_LAST);
  assign tx_roll_lim = (mode == spfm_pkg::SPFM_MODE1) ? spfm_pkg::TX_ROLL_M1
                                                      : spfm_pkg::TX_ROLL_M23;
  assign atx_set     = (atx_state == spfm_pkg::ATX_RUN) && roll
                       && (tx_roll + 4'h1 == tx_roll_lim); // [RULE_11] [RULE_12]

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      tdiv <= 4'h0;
    else if (tick)
      tdiv <= tdiv + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      atx_state <= spfm_pkg::ATX_IDLE;
      tx_sh     <= 11'h7FF;
      tx_roll   <= 4'h0;
    end
    else if (mode == spfm_pkg::SPFM_MODE0)
      atx_state <= spfm_pkg::ATX_IDLE;
    else if (serial_buffer_we_i)
    begin
      atx_state <= spfm_pkg::ATX_RUN; // [RULE_11] [RULE_23]
      tx_roll   <= 4'h0;
      if (mode == spfm_pkg::SPFM_MODE1)
        tx_sh <= {2'b11, serial_buffer_wdata_i, 1'b0}; // [RULE_09]
      else
        tx_sh <= {1'b1, tx_ninth_bit_i, serial_buffer_wdata_i, 1'b0}; // [RULE_18] [RULE_20]
    end
    else if (atx_state == spfm_pkg::ATX_RUN && roll)
    begin
      tx_sh   <= {1'b1, tx_sh[10:1]}; // [RULE_11]
      tx_roll <= tx_roll + 4'h1;
      if (atx_set)
        atx_state <= spfm_pkg::ATX_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Serial pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      txd_o <= 1'b1;
    else if (mode == spfm_pkg::SPFM_MODE0)
    begin
      if (m0_state == spfm_pkg::M0_IDLE || m0_rise)
        txd_o <= 1'b1; // [RULE_01]
      else if (m0_fall)
        txd_o <= 1'b0;
    end
    else if (atx_state == spfm_pkg::ATX_RUN && roll)
      txd_o <= tx_sh[0]; // [RULE_09] [RULE_11]
    else if (atx_state == spfm_pkg::ATX_IDLE)
      txd_o <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rxd_o      <= 1'b1;
      rxd_oe_n_o <= 1'b1;
    end
    else if (mode == spfm_pkg::SPFM_MODE0 && serial_buffer_we_i)
    begin
      rxd_o      <= serial_buffer_wdata_i[0]; // [RULE_01]
      rxd_oe_n_o <= 1'b0;
    end
    else if (m0_state == spfm_pkg::M0_TX && !m0_end)
    begin
      if (m0_cnt == m0_per - 4'h1)
        rxd_o <= m0_sh[1]; // [RULE_03] [RULE_04]
      rxd_oe_n_o <= 1'b0;
    end
    else
    begin
      rxd_o      <= 1'b1;
      rxd_oe_n_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Asynchronous receiver
  // ---------------------------------------------------------------
  assign rx_last_idx = (mode == spfm_pkg::SPFM_MODE1) ? spfm_pkg::RX_LAST_M1
                                                      : spfm_pkg::RX_LAST_M23;
  assign vote      = (vote_a & vote_b) | (vote_a & rxd_s) | (vote_b & rxd_s); // [RULE_14]
  assign rx_decide = (arx_state == spfm_pkg::ARX_BITS) && tick && (rdiv == spfm_pkg::SAMPLE_C);
  assign arx_final = rx_decide && (rcnt == rx_last_idx);
  assign arx_load  = arx_final && !rx_done_flag_o
                     && (!speed_or_filter_select_i || vote); // [RULE_16]
  assign arx_data  = (mode == spfm_pkg::SPFM_MODE1) ? rx_sh[8:1] : rx_sh[7:0];
  assign arx_ninth = (mode == spfm_pkg::SPFM_MODE1) ? vote : rx_sh[8];

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      arx_state <= spfm_pkg::ARX_HUNT;
      rx_last   <= 1'b1;
      rdiv      <= 4'h0;
      rcnt      <= 4'h0;
      vote_a    <= 1'b1;
      vote_b    <= 1'b1;
      rx_sh     <= 9'h000;
    end
    else if (mode == spfm_pkg::SPFM_MODE0 || !rx_enable_i) // [RULE_22]
    begin
      arx_state <= spfm_pkg::ARX_HUNT;
      rx_last   <= rxd_s;
    end
    else if (tick)
    begin
      rx_last <= rxd_s;
      unique case (arx_state)
        spfm_pkg::ARX_HUNT:
        begin
          if (rx_last && !rxd_s)
          begin
            arx_state <= spfm_pkg::ARX_BITS; // [RULE_13]
            rdiv      <= 4'h0;
            rcnt      <= 4'h0;
          end
        end
        spfm_pkg::ARX_BITS:
        begin
          rdiv <= rdiv + 4'h1;
          if (rdiv == spfm_pkg::SAMPLE_A)
            vote_a <= rxd_s; // [RULE_14]
          if (rdiv == spfm_pkg::SAMPLE_B)
            vote_b <= rxd_s; // [RULE_14]
          if (rdiv == spfm_pkg::SAMPLE_C)
          begin
            rcnt <= rcnt + 4'h1;
            if (rcnt == 4'h0 && vote)
              arx_state <= spfm_pkg::ARX_HUNT; // [RULE_15]
            else if (rcnt == rx_last_idx)
              arx_state <= spfm_pkg::ARX_HUNT; // [RULE_17]
            else if (rcnt != 4'h0)
              rx_sh <= {vote, rx_sh[8:1]};
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer and flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      serial_buffer_o <= 8'h00;
      rx_ninth_bit_o  <= 1'b0;
    end
    else if (m0_rx_set)
      serial_buffer_o <= {rxd_s, m0_sh[7:1]}; // [RULE_08]
    else if (arx_load)
    begin
      serial_buffer_o <= arx_data; // [RULE_16] [RULE_23]
      rx_ninth_bit_o  <= arx_ninth; // [RULE_18]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      tx_done_flag_o <= 1'b0;
    else
      tx_done_flag_o <= m0_tx_set | atx_set | (tx_done_flag_o & ~tx_done_clr_i); // [RULE_25]
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      rx_done_flag_o <= 1'b0;
    else
      rx_done_flag_o <= m0_rx_set | arx_load | (rx_done_flag_o & ~rx_done_clr_i); // [RULE_25]
  end

endmodule : spfm_serial_port

// *** dv/spfm_serial_port_checker.sv ***
// Port-level assertions for the four-mode serial port
`timescale 1ns/100ps
module spfm_serial_port_checker (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       mode_select_low_i,
  input wire logic       mode_select_high_i,
  input wire logic       speed_or_filter_select_i,
  input wire logic       baud_doubler_i,
  input wire logic       serial_buffer_we_i,
  input wire logic       tx_done_clr_i,
  input wire logic       rx_done_clr_i,
  input wire logic [7:0] serial_buffer_o,
  input wire logic       tx_done_flag_o,
  input wire logic       rx_done_flag_o,
  input wire logic       txd_o,
  input wire logic       rxd_o,
  input wire logic       rxd_oe_n_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic       m0;
  logic       m0tx;
  logic       m2;
  logic       slow;
  logic [9:0] low_run;
  assign m0   = !mode_select_high_i && !mode_select_low_i;
  assign m0tx = m0 && !rxd_oe_n_o;
  assign m2   = mode_select_high_i && !mode_select_low_i;
  assign slow = !speed_or_filter_select_i;
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || txd_o)
      low_run <= 10'h000;
    else
      low_run <= low_run + 10'h001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reset_idle_a: assert property (disable iff (1'b0) !resetn_i |=> txd_o && rxd_oe_n_o
    && !tx_done_flag_o && !rx_done_flag_o) else $error("outputs not idle in reset");
  m0_slow_low_a: assert property ($fell(txd_o) && m0tx && slow
    |-> !txd_o [*6] ##1 txd_o) else $error("slow shift clock low time");
  m0_fast_low_a: assert property ($fell(txd_o) && m0tx && !slow
    |-> !txd_o [*2] ##1 txd_o) else $error("fast shift clock low time");
  m0_slow_setup_a: assert property ($fell(txd_o) && m0tx && slow
    |-> !$past(rxd_oe_n_o, 3) && rxd_o == $past(rxd_o, 3)) else $error("slow data setup");
  m0_fast_setup_a: assert property ($fell(txd_o) && m0tx && !slow
    |-> !$past(rxd_oe_n_o) && $stable(rxd_o)) else $error("fast data setup");
  m0_tx_done_a: assert property ($rose(rxd_oe_n_o) && m0 |=> tx_done_flag_o)
    else $error("transmit done late");
  tx_sticky_a: assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o)
    else $error("transmit done lost");
  rx_sticky_a: assert property (rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o)
    else $error("receive done lost");
  m0_rx_halt_a: assert property (m0 && rx_done_flag_o && rxd_oe_n_o && txd_o
    && !serial_buffer_we_i |=> txd_o) else $error("shift clock while receive done");
  m2_bit_len_a: assert property ($rose(txd_o) && m2 |-> low_run[4:0] == 5'h00
    && (baud_doubler_i || !low_run[5])) else $error("mode 2 bit length");
  buf_load_a: assert property (!$stable(serial_buffer_o) |-> $rose(rx_done_flag_o))
    else $error("buffer changed without receive done");
endmodule : spfm_serial_port_checker

// *** dv/spfm_far_end.sv ***
// Far-end serial device model for the four-mode serial port
`timescale 1ns/100ps
module spfm_far_end (
  input  wire logic txd_i,
  input  wire logic line_i,
  output logic      line_o
);
  // ----------------------------------------------------------------
  // Mode 0 shift partner
  // ----------------------------------------------------------------
  logic [7:0] m0_tx;
  logic [7:0] m0_cap;
  logic       m0_drive;
  int         m0_n;
  realtime    last_rise;
  realtime    m0_per;
  initial
  begin
    line_o    = 1'b1;
    m0_drive  = 1'b0;
    m0_n      = 0;
    last_rise = 0;
  end
  always @(negedge txd_i)
    if (m0_drive && m0_n < 8)
    begin
      line_o = m0_tx[m0_n];
      m0_n   = m0_n + 1;
    end
  always @(posedge txd_i)
  begin
    m0_cap    = {line_i, m0_cap[7:1]};
    m0_per    = $realtime - last_rise;
    last_rise = $realtime;
    if (m0_drive && m0_n == 8)
    begin
      m0_drive = 1'b0;
      #120 line_o = 1'b1;
    end
  end
  task automatic arm(input logic [7:0] d);
    m0_tx    = d;
    m0_n     = 0;
    m0_drive = 1'b1;
  endtask : arm
  // ----------------------------------------------------------------
  // Asynchronous frames
  // ----------------------------------------------------------------
  task automatic send(input logic [10:0] bits, input int n, input realtime bt);
    for (int i = 0; i < n; i++)
    begin
      line_o = bits[i];
      #(bt);
    end
    line_o = 1'b1;
  endtask : send
  task automatic get(output logic [10:0] bits, input int n, input realtime bt);
    bits = 11'h7FF;
    @(negedge txd_i);
    #(bt / 2);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txd_i;
      if (i < n - 1)
        #(bt);
    end
  endtask : get
endmodule : spfm_far_end

// *** dv/spfm_serial_port_test.sv ***
// Self-checking bench for the four-mode serial port
`timescale 1ns/100ps
module spfm_serial_port_test;
  logic        clk_i, resetn_i, link_clk_i, link_resetn_i, timer_ovf_i;
  logic        mode_select_low_i, mode_select_high_i, speed_or_filter_select_i;
  logic        baud_doubler_i, rx_enable_i, tx_ninth_bit_i, serial_buffer_we_i;
  logic        tx_done_clr_i, rx_done_clr_i, rxd_i, rx_ninth_bit_o, far_line;
  logic        tx_done_flag_o, rx_done_flag_o, txd_o, rxd_o, rxd_oe_n_o;
  logic [7:0]  serial_buffer_wdata_i, serial_buffer_o;
  logic [2:0]  ovf_cnt;
  logic [10:0] got;
  int          n_mismatch, checked, cycles;
  // ----------------------------------------------------------------
  // Design, far end and clocks
  // ----------------------------------------------------------------
  spfm_serial_port spfm_serial_port_i (.*);
  spfm_far_end spfm_far_end_i (.txd_i(txd_o), .line_i(rxd_i), .line_o(far_line));
  assign rxd_i = rxd_oe_n_o ? far_line : rxd_o;
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #7;
    forever #16 link_clk_i = ~link_clk_i;
  end
  always @(posedge link_clk_i)
  begin
    ovf_cnt     <= link_resetn_i ? ovf_cnt + 3'h1 : 3'h0;
    timer_ovf_i <= link_resetn_i && ovf_cnt == 3'h7;
  end
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic setup(input logic [1:0] m, input logic sel, input logic dbl, input logic en);
    @(posedge clk_i);
    {mode_select_high_i, mode_select_low_i} <= m;
    speed_or_filter_select_i <= sel;
    baud_doubler_i <= dbl;
    rx_enable_i <= en;
    tx_done_clr_i <= 1'b1;
    rx_done_clr_i <= 1'b1;
    @(posedge clk_i);
    tx_done_clr_i <= 1'b0;
    rx_done_clr_i <= 1'b0;
  endtask : setup
  task automatic write(input logic [7:0] d, input logic n9);
    @(posedge clk_i);
    serial_buffer_wdata_i <= d;
    tx_ninth_bit_i <= n9;
    serial_buffer_we_i <= 1'b1;
    @(posedge clk_i);
    serial_buffer_we_i <= 1'b0;
  endtask : write
  task automatic await(input logic rx);
    int k;
    k = 0;
    while ((rx ? rx_done_flag_o : tx_done_flag_o) !== 1'b1 && k < 4000)
    begin
      @(negedge clk_i);
      k = k + 1;
    end
    check(rx ? rx_done_flag_o : tx_done_flag_o, 1'b1);
  endtask : await
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [1:0]  m;
    logic        dbl;
    realtime     bt;
    logic [7:0]  d;
    logic [10:0] exp;
    {resetn_i, link_resetn_i, timer_ovf_i, ovf_cnt, rx_enable_i} = '0;
    {mode_select_low_i, mode_select_high_i, speed_or_filter_select_i} = '0;
    {baud_doubler_i, tx_ninth_bit_i, serial_buffer_wdata_i, serial_buffer_we_i} = '0;
    {tx_done_clr_i, rx_done_clr_i, n_mismatch, checked, cycles} = '0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    link_resetn_i <= 1'b1;
    @(negedge clk_i);
    check({txd_o, rxd_o, rxd_oe_n_o, tx_done_flag_o, rx_done_flag_o, rx_ninth_bit_o,
           serial_buffer_o}, 16'h3800);
    for (int s = 0; s < 2; s++)
    begin
      setup(2'h0, s[0], 1'b0, 1'b0);
      write(8'hB4 ^ 8'(s), 1'b0);
      await(1'b0);
      check(spfm_far_end_i.m0_cap, 8'hB4 ^ 8'(s));
      check(int'(spfm_far_end_i.m0_per), s ? 200 : 600);
    end
    spfm_far_end_i.arm(8'h1D);
    setup(2'h0, 1'b0, 1'b0, 1'b1);
    await(1'b1);
    check(serial_buffer_o, 8'h1D);
    repeat (60) @(negedge clk_i);
    check({rx_done_flag_o, txd_o}, 2'h3);
    for (int i = 0; i < 6; i++)
    begin
      m   = 2'(i % 3 + 1);
      dbl = i > 2;
      bt  = m == 2'h2 ? (dbl ? 1600 : 3200) : (dbl ? 4096 : 8192);
      d   = 8'h29 + 8'(i * 37);
      exp = {1'b1, m == 2'h1 ? 1'b1 : i[0], d, 1'b0};
      setup(m, 1'b0, dbl, 1'b1);
      fork
        spfm_far_end_i.get(got, m == 2'h1 ? 10 : 11, bt);
        spfm_far_end_i.send(exp, 11, bt);
        write(d, i[0]);
      join
      check(got, exp);
      await(1'b0);
      await(1'b1);
      check({rx_ninth_bit_o, serial_buffer_o}, exp[9:1]);
    end
    setup(2'h1, 1'b1, 1'b1, 1'b1);
    spfm_far_end_i.send({2'h2, 8'h66, 1'b0}, 11, 4096);
    check(rx_done_flag_o, 1'b0);
    spfm_far_end_i.send(11'h000, 1, 1000);
    spfm_far_end_i.send(11'h7FF, 2, 4096);
    check(rx_done_flag_o, 1'b0);
    spfm_far_end_i.send({2'h3, 8'h3A, 1'b0}, 11, 4096);
    await(1'b1);
    check({rx_ninth_bit_o, serial_buffer_o}, 9'h13A);
    spfm_far_end_i.send({2'h3, 8'h77, 1'b0}, 11, 4096);
    repeat (10) @(negedge clk_i);
    check({rx_done_flag_o, serial_buffer_o}, 9'h13A);
    conclude();
  end
endmodule : spfm_serial_port_test

bind spfm_serial_port spfm_serial_port_checker spfm_serial_port_checker_i (.*);
